// *** rtl/siu_pkg.sv ***
// Package: constants, types and register map of the system integration unit
package siu_pkg;

  // ****************************************************************
  // Register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [3:0] SIU_IDX_CONTROL = 4'h0;
  localparam logic [3:0] SIU_IDX_STATUS  = 4'h1;
  localparam logic [3:0] SIU_IDX_SECURE  = 4'h2;
  localparam logic [3:0] SIU_IDX_PCG     = 4'hC;
  localparam logic [3:0] SIU_IDX_SAH     = 4'hD;
  localparam logic [3:0] SIU_IDX_SAL     = 4'hE;
  localparam int         SIU_ADDR_W      = 6;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SIU_PCG_SERIAL_PORT_ZERO_GATE = 2;
  localparam int SIU_PCG_MODULATOR_B_GATE = 1;
  localparam int SIU_PCG_MODULATOR_A_GATE = 0;
  localparam logic [15:0] SIU_PCG_RST  = 16'hFFFF;
  localparam logic [1:0]  SIU_SAH_RST  = 2'h3;
  localparam logic [15:0] SIU_SAL_RST  = 16'hFFFF;
  localparam logic [13:0] SIU_SAH_ONES = 14'h3FFF;
  localparam logic [17:0] SIU_SA_DEBUG = 18'h3FFFF;
  localparam int SIU_SA_LOW = 6;

  // Control register bits
  localparam int SIU_CTL_STOP_TMP = 0;
  localparam int SIU_CTL_WAIT_TMP = 1;
  localparam int SIU_CTL_STOP_PRM = 2;
  localparam int SIU_CTL_WAIT_PRM = 3;
  localparam int SIU_CTL_SWRST    = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SIU_POR_STRETCH = 2097152;
  localparam int SIU_WIN_CYCLES  = 32;
  localparam int SIU_SA_PIPE     = 3;
  localparam int SIU_CNT_W       = 22;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    SIU_RS_HOLD  = 6'b000001,
    SIU_RS_POR   = 6'b000010,
    SIU_RS_CLK   = 6'b000100,
    SIU_RS_PERI  = 6'b001000,
    SIU_RS_CORE  = 6'b010000,
    SIU_RS_RUN   = 6'b100000
  } siu_rst_t;

  typedef enum logic [2:0] {
    SIU_PM_RUN  = 3'b001,
    SIU_PM_WAIT = 3'b010,
    SIU_PM_STOP = 3'b100
  } siu_pm_t;

  typedef struct packed {
    logic stop_req;
    logic wait_req;
    logic irq;
    logic nonclk_irq;
    logic can_act;
  } siu_core_t;

  typedef struct packed {
    logic core_en;
    logic periph_en;
    logic clk_run;
    logic periph_rel;
    logic core_rel;
  } siu_gate_t;

endpackage : siu_pkg

// *** rtl/siu_top.sv ***
// System integration unit: clocks, power modes, reset sequence, short address, security
// Notes on behaviour
// - Gate register bit 2 enables serial port zero clock.
// - Gate bit 1 enables modulator B clock, bit 0 modulator A.
// - Gate bit one passes the clock; zero withholds it, peripheral disabled.
// - Short addressing: instruction gives low six bits, pair gives the rest.
// - High register holds address bits 23:22 in bits 1:0; upper bits read one.
// - Low register holds address bits 21:6 in bits 15:0.
// - After reset the pair points at top of memory, debug space.
// - Pair off debug space with external flag set blocks JTAG debug access.
// - New pair value reaches short-addressed accesses four cycles after write.
// - System and peripheral clocks run at half master clock, max 60MHz.
// - Run mode: core and peripheral clocks active.
// - Wait stops core and memory clocks; unmasked interrupt wakes the core.
// - Stop ends only by CAN traffic, unclocked interrupt, watchdog, external, power-on; here a software reset also ends it.
// - All peripherals but watchdog run on peripheral bus clock, max 60MHz.
// - Stop does not shut PLL; software disables it first.
// - Stop and wait instructions disable temporarily or until next reset.
// - Four reset sources: pin and power-on async, software and watchdog sync.
// - Power-on reset stretched 2^21 cycles, then three ordered 32-cycle windows.
// - Pin and power-on resets assert asynchronously; all resets release on a rising system clock edge.
// - Security blocks external program space, boot select and core debug.
// - Two non-volatile flash bytes decide security, persisting across resets.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module siu_top
  import siu_pkg::*;
#(
  parameter int POR_STRETCH = SIU_POR_STRETCH,
  parameter int WIN_CYCLES  = SIU_WIN_CYCLES
) (
  input  wire logic                  system_clock,
  input  wire logic                  nrst,
  input  wire logic                  por_n,
  input  wire logic                  ext_rst_n,
  input  wire logic                  watchdog_rst,
  input  wire logic [SIU_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire siu_core_t             core_in,
  input  wire logic [5:0]            short_offset,
  input  wire logic                  external_memory_flag,
  input  wire logic [7:0]            security_byte_lo,
  input  wire logic [7:0]            security_byte_hi,
  input  wire logic                  external_boot_select,
  output logic [23:0]                short_address,
  output logic [15:0]                peripheral_clock_gate,
  output logic                       system_clock_en,
  output logic                       peripheral_clock_en,
  output siu_gate_t                  gate_out,
  output logic                       debug_access_en,
  output logic                       ext_program_en,
  output logic                       boot_external,
  output logic                       secure_mode
);

  // ****************************************************************
  // Reset source synchronisers and release
  // ****************************************************************
  logic [1:0] ext_sync_reg;
  logic       wd_meta_reg, wd_sync_reg;
  wire        async_any_n = nrst & por_n & ext_rst_n;

  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) ext_sync_reg <= 2'h0;
    else              ext_sync_reg <= {ext_sync_reg[0], 1'b1};
  end

  always_ff @(posedge system_clock or negedge nrst) begin
    if (!nrst) begin
      wd_meta_reg <= 1'b0;
      wd_sync_reg <= 1'b0;
    end else begin
      wd_meta_reg <= watchdog_rst;
      wd_sync_reg <= wd_meta_reg;
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  siu_rst_t             rs_reg, rs_next;
  logic [SIU_CNT_W-1:0] cnt_reg, cnt_next;
  logic                 por_seen_reg;
  logic                 sw_rst_reg;
  wire                  sync_rst = wd_sync_reg | sw_rst_reg;
  wire                  win_done = (cnt_reg == SIU_CNT_W'(WIN_CYCLES - 1));
  wire                  por_done = (cnt_reg == SIU_CNT_W'(POR_STRETCH - 1));

  always_comb begin
    rs_next  = rs_reg;
    cnt_next = cnt_reg + 1'b1;
    unique case (rs_reg)
      SIU_RS_HOLD: begin
        cnt_next = '0;
        rs_next  = por_seen_reg ? SIU_RS_POR : SIU_RS_CLK;
      end
      SIU_RS_POR: if (por_done) begin
        rs_next  = SIU_RS_CLK;
        cnt_next = '0;
      end
      SIU_RS_CLK: if (win_done) begin
        rs_next  = SIU_RS_PERI;
        cnt_next = '0;
      end
      SIU_RS_PERI: if (win_done) begin
        rs_next  = SIU_RS_CORE;
        cnt_next = '0;
      end
      SIU_RS_CORE: if (win_done) begin
        rs_next  = SIU_RS_RUN;
        cnt_next = '0;
      end
      SIU_RS_RUN: begin
        cnt_next = '0;
        if (sync_rst) rs_next = SIU_RS_HOLD;
      end
    endcase
  end

  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) begin
      rs_reg  <= SIU_RS_HOLD;
      cnt_reg <= '0;
    end else if (!ext_sync_reg[1]) begin
      rs_reg  <= SIU_RS_HOLD;
      cnt_reg <= '0;
    end else begin
      rs_reg  <= rs_next;
      cnt_reg <= cnt_next;
    end
  end

  // Power-on flag: set by power-on, cleared once its stretch starts
  always_ff @(posedge system_clock or negedge por_n) begin
    if (!por_n)                    por_seen_reg <= 1'b1;
    else if (rs_reg == SIU_RS_POR) por_seen_reg <= 1'b0;
  end

  wire in_reset   = (rs_reg != SIU_RS_RUN);
  wire clk_run    = (rs_reg == SIU_RS_PERI) | (rs_reg == SIU_RS_CORE) | (rs_reg == SIU_RS_RUN);
  wire periph_rel = (rs_reg == SIU_RS_CORE) | (rs_reg == SIU_RS_RUN);

  // ****************************************************************
  // Avalon slave and registers
  // ****************************************************************
  logic        ack_reg;
  logic [15:0] pcg_reg;
  logic [1:0]  sah_reg;
  logic [15:0] sal_reg;
  logic [3:0]  ctl_reg;
  logic [1:0]  perm_reg;
  logic        sec_reg;
  logic [17:0] sa_pipe_reg [SIU_SA_PIPE];

  wire [3:0] idx    = avs_address[SIU_ADDR_W-1:2];
  wire       req    = (avs_read | avs_write) & ~ack_reg;
  wire       wr     = avs_write & ~ack_reg & avs_byteenable[0] & avs_byteenable[1];
  wire       wr_ctl = wr & (idx == SIU_IDX_CONTROL);
  wire       wr_pcg = wr & (idx == SIU_IDX_PCG);
  wire       wr_sah = wr & (idx == SIU_IDX_SAH);
  wire       wr_sal = wr & (idx == SIU_IDX_SAL);
  wire [15:0] sah_view = {SIU_SAH_ONES, sah_reg};
  wire [15:0] stat_view = {2'h0, external_boot_select, sec_reg, perm_reg, ctl_reg, rs_reg};
  wire [15:0] rd_mux =
      (idx == SIU_IDX_CONTROL) ? {12'h000, ctl_reg} :
      (idx == SIU_IDX_STATUS)  ? stat_view :
      (idx == SIU_IDX_SECURE)  ? {security_byte_hi, security_byte_lo} :
      (idx == SIU_IDX_PCG)     ? pcg_reg :
      (idx == SIU_IDX_SAH)     ? sah_view :
      (idx == SIU_IDX_SAL)     ? sal_reg : 16'h0000;

  // One wait cycle, answer on the second edge
  always_ff @(posedge system_clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      ack_reg         <= req;
      avs_waitrequest <= ~req;
      if (req) avs_readdata <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) begin
      pcg_reg    <= SIU_PCG_RST;
      sah_reg    <= SIU_SAH_RST;
      sal_reg    <= SIU_SAL_RST;
      ctl_reg    <= 4'h0;
      perm_reg   <= 2'h0;
      sw_rst_reg <= 1'b0;
    end else if (in_reset) begin
      pcg_reg    <= SIU_PCG_RST;
      sah_reg    <= SIU_SAH_RST;
      sal_reg    <= SIU_SAL_RST;
      ctl_reg    <= 4'h0;
      perm_reg   <= 2'h0;
      sw_rst_reg <= 1'b0;
    end else begin
      if (wr_pcg) pcg_reg <= avs_writedata[15:0];
      if (wr_sah) sah_reg <= avs_writedata[1:0];
      if (wr_sal) sal_reg <= avs_writedata[15:0];
      if (wr_ctl) ctl_reg <= avs_writedata[3:0];
      // Permanent disables stick until the next reset
      if (wr_ctl) perm_reg <= perm_reg | avs_writedata[SIU_CTL_WAIT_PRM:SIU_CTL_STOP_PRM];
      sw_rst_reg <= wr_ctl & avs_writedata[SIU_CTL_SWRST];
    end
  end

  // ****************************************************************
  // Short address pipeline and debug interlock
  // ****************************************************************
  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) begin
      for (int i = 0; i < SIU_SA_PIPE; i++) sa_pipe_reg[i] <= SIU_SA_DEBUG;
    end else begin
      sa_pipe_reg[0] <= {sah_reg, sal_reg};
      for (int i = 1; i < SIU_SA_PIPE; i++) sa_pipe_reg[i] <= sa_pipe_reg[i-1];
    end
  end

  // Security latched from the flash bytes during the peripheral window
  wire sec_decode = (security_byte_hi != security_byte_lo);
  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n)              sec_reg <= 1'b1;
    else if (rs_reg == SIU_RS_PERI) sec_reg <= sec_decode;
  end

  wire sa_is_debug = (sa_pipe_reg[SIU_SA_PIPE-1] == SIU_SA_DEBUG);

  // ****************************************************************
  // Power modes
  // ****************************************************************
  siu_pm_t pm_reg, pm_next;
  wire stop_ok = core_in.stop_req & ~ctl_reg[SIU_CTL_STOP_TMP] & ~perm_reg[0];
  wire wait_ok = core_in.wait_req & ~ctl_reg[SIU_CTL_WAIT_TMP] & ~perm_reg[1];

  always_comb begin
    pm_next = pm_reg;
    unique case (pm_reg)
      SIU_PM_RUN: begin
        if (stop_ok)      pm_next = SIU_PM_STOP;
        else if (wait_ok) pm_next = SIU_PM_WAIT;
      end
      SIU_PM_WAIT: if (core_in.irq) pm_next = SIU_PM_RUN;
      SIU_PM_STOP: if (core_in.can_act | core_in.nonclk_irq) pm_next = SIU_PM_RUN;
    endcase
  end

  // Watchdog, external and power-on exits go through reset
  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n)  pm_reg <= SIU_PM_RUN;
    else if (in_reset) pm_reg <= SIU_PM_RUN;
    else               pm_reg <= pm_next;
  end

  // ****************************************************************
  // Clock enables and outputs
  // ****************************************************************
  logic half_reg;
  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) half_reg <= 1'b0;
    else              half_reg <= ~half_reg;
  end

  wire core_on   = (pm_reg == SIU_PM_RUN) & ~in_reset;
  wire periph_on = ((pm_reg == SIU_PM_RUN) | (pm_reg == SIU_PM_WAIT)) & clk_run;

  always_ff @(posedge system_clock or negedge async_any_n) begin
    if (!async_any_n) begin
      short_address         <= 24'h000000;
      peripheral_clock_gate <= 16'h0000;
      system_clock_en       <= 1'b0;
      peripheral_clock_en   <= 1'b0;
      gate_out              <= '0;
      debug_access_en       <= 1'b0;
      ext_program_en        <= 1'b0;
      boot_external         <= 1'b0;
      secure_mode           <= 1'b1;
    end else begin
      short_address         <= {sa_pipe_reg[SIU_SA_PIPE-1], short_offset};
      peripheral_clock_gate <= pcg_reg & {16{periph_on & half_reg}};
      system_clock_en       <= core_on & half_reg;
      peripheral_clock_en   <= periph_on & half_reg;
      gate_out              <= '{core_en: core_on, periph_en: periph_on, clk_run: clk_run,
                                 periph_rel: periph_rel, core_rel: ~in_reset};
      debug_access_en       <= ~sec_reg & (sa_is_debug | ~external_memory_flag);
      ext_program_en        <= ~sec_reg;
      boot_external         <= external_boot_select & ~sec_reg;
      secure_mode           <= sec_reg;
    end
  end

endmodule : siu_top

// *** test/siu_chk.sv ***
// Checker: port-level assertions of the system integration unit
`timescale 1ns/1ps
module siu_chk
  import siu_pkg::*;
#(
  parameter int WIN_CYCLES = 32
) (
  input wire logic                  system_clock,
  input wire logic                  nrst,
  input wire logic                  por_n,
  input wire logic                  ext_rst_n,
  input wire logic [SIU_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic                  avs_waitrequest,
  input wire logic [5:0]            short_offset,
  input wire logic [23:0]           short_address,
  input wire logic                  system_clock_en,
  input wire siu_gate_t             gate_out,
  input wire logic                  debug_access_en,
  input wire logic                  ext_program_en,
  input wire logic                  boot_external,
  input wire logic                  secure_mode
);
  localparam int WLO = WIN_CYCLES - 2;
  localparam int WHI = 2 * WIN_CYCLES + 2;
  wire in_rst = !nrst || !por_n || !ext_rst_n;
  default clocking @(posedge system_clock); endclocking
  default disable iff (in_rst);

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_acked;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_sal_wr;
    avs_write && !avs_waitrequest && avs_address[5:2] == SIU_IDX_SAL && avs_byteenable[1:0] == 2'h3 && gate_out.core_rel;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_bus_ack_next: assert property (s_taken |=> s_acked) else $error("bus answer not one cycle");
  chk_offset_pass: assert property ($past(!in_rst) |-> short_address[5:0] == $past(short_offset))
    else $error("short offset not passed");
  chk_pair_delay: assert property (s_sal_wr |-> ##5 short_address[21:6] == $past(avs_writedata[15:0], 5))
    else $error("short pair late");
  chk_secure_debug: assert property (secure_mode |-> !debug_access_en) else $error("debug open while secure");
  chk_secure_ext: assert property (secure_mode |-> !ext_program_en && !boot_external)
    else $error("external access while secure");
  chk_core_after_peri: assert property ($rose(gate_out.core_rel) |-> gate_out.periph_rel && gate_out.clk_run)
    else $error("core released out of order");
  chk_peri_after_clk: assert property ($rose(gate_out.periph_rel) |-> gate_out.clk_run && !gate_out.core_rel)
    else $error("peripherals released out of order");
  chk_window_len: assert property ($rose(gate_out.periph_rel) |-> ##[WLO:WHI] gate_out.core_rel)
    else $error("core window length wrong");
  chk_half_rate: assert property (gate_out.core_en && $past(gate_out.core_en) |->
      system_clock_en != $past(system_clock_en)) else $error("system clock not half rate");
endmodule : siu_chk

bind siu_top siu_chk #(.WIN_CYCLES(WIN_CYCLES)) chk_u (.system_clock, .nrst, .por_n, .ext_rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .short_offset, .short_address, .system_clock_en,
  .gate_out, .debug_access_en, .ext_program_en, .boot_external, .secure_mode);

// *** test/siu_core_model.sv ***
// Partner model: core flags, instruction offsets and flash security bytes
`timescale 1ns/1ps
module siu_core_model
  import siu_pkg::*;
(
  input wire logic   system_clock,
  input wire logic   nrst,
  input wire logic   lock,
  input wire logic   ext_mem,
  input wire siu_core_t core_req,
  output siu_core_t  core_in,
  output logic [5:0] short_offset,
  output logic       external_memory_flag,
  output logic [7:0] security_byte_lo,
  output logic [7:0] security_byte_hi,
  output logic       external_boot_select
);
  logic [5:0] off_reg;
  always_ff @(posedge system_clock or negedge nrst) begin
    if (!nrst) off_reg <= 6'h00;
    else off_reg <= off_reg + 6'h01;
  end
  assign short_offset         = off_reg;
  assign core_in              = core_req;
  assign external_memory_flag = ext_mem;
  assign security_byte_lo     = 8'hA5;
  assign security_byte_hi     = lock ? 8'h5A : 8'hA5;
  assign external_boot_select = 1'b1;
endmodule : siu_core_model

// *** test/system_clock_reset_power_control_bench.sv ***
// Bench: register table, short addressing, reset sequencing and security
`timescale 1ns/1ps
module system_clock_reset_power_control_bench;
  import siu_pkg::*;
  localparam int POR = 64;
  localparam int WIN = 4;
  typedef struct {logic wr; logic [3:0] idx; logic [15:0] wd; logic [15:0] exp;} siu_row_t;
  logic        system_clock, nrst, por_n, ext_rst_n, watchdog_rst, avs_read, avs_write, lock, ext_mem, flag, boot_sel;
  logic        avs_waitrequest, system_clock_en, peripheral_clock_en, debug_access_en, ext_program_en;
  logic        boot_external, secure_mode, g1, g2;
  logic [5:0]  avs_address, short_offset;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [23:0] short_address;
  logic [15:0] peripheral_clock_gate;
  logic [7:0]  sec_lo, sec_hi;
  siu_core_t   core_in, core_req;
  siu_gate_t   gate_out;
  int          mismatches, cmp_count, n;
  siu_row_t    rows[7] = '{'{0, SIU_IDX_PCG, 0, 16'hFFFF}, '{0, SIU_IDX_SAH, 0, 16'hFFFF}, '{0, SIU_IDX_SAL, 0, 16'hFFFF},
    '{1, SIU_IDX_PCG, 16'h0005, 16'h0005}, '{1, SIU_IDX_SAH, 16'h0001, 16'hFFFD},
    '{1, SIU_IDX_SAL, 16'h1234, 16'h1234}, '{1, 4'h7, 16'hABCD, 16'h0000}};

  siu_top #(.POR_STRETCH(POR), .WIN_CYCLES(WIN)) dut_u (.system_clock, .nrst, .por_n, .ext_rst_n, .watchdog_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_in,
    .short_offset, .external_memory_flag(flag), .security_byte_lo(sec_lo), .security_byte_hi(sec_hi),
    .external_boot_select(boot_sel), .short_address, .peripheral_clock_gate, .system_clock_en, .peripheral_clock_en,
    .gate_out, .debug_access_en, .ext_program_en, .boot_external, .secure_mode);
  siu_core_model model_u (.system_clock, .nrst, .lock, .ext_mem, .core_req, .core_in, .short_offset, .external_memory_flag(flag),
    .security_byte_lo(sec_lo), .security_byte_hi(sec_hi), .external_boot_select(boot_sel));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : cmp_val
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] wd);
    int k;
    k = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge system_clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge system_clock);
    if (k >= 20) begin
      mismatches++;
      stop_test();
    end
  endtask : bus
  task automatic wait_rel(input logic v);
    n = 0;
    while (gate_out.core_rel !== v && n < 500) begin
      @(posedge system_clock);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_rel
  task automatic pm_step(input logic [4:0] r, input logic [1:0] e);
    core_req <= r;
    @(posedge system_clock);
    core_req <= 5'h00;
    repeat (2) @(posedge system_clock);
    cmp_val("power gates", {30'h0, e}, {30'h0, gate_out.core_en, gate_out.periph_en});
  endtask : pm_step

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    system_clock = 1'b0;
    forever #12.5 system_clock = ~system_clock;
  end
  initial begin
    {nrst, por_n, ext_rst_n, watchdog_rst, avs_read, avs_write, lock, ext_mem} = 8'h20;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    core_req = 5'h00;
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(posedge system_clock);
    nrst <= 1'b1;
    por_n <= 1'b1;
    wait_rel(1'b1);
    cmp_val("power-on stretch", 1, n >= POR + 3 * WIN);
    cmp_val("secure after power-on", 0, secure_mode);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 16'h0000);
      cmp_val($sformatf("register %h", rows[i].idx), {16'h0000, rows[i].exp}, rd);
    end
    {g1, g2} = 2'b00;
    repeat (8) begin
      @(posedge system_clock);
      g1 |= peripheral_clock_gate[SIU_PCG_MODULATOR_B_GATE];
      g2 |= peripheral_clock_gate[SIU_PCG_SERIAL_PORT_ZERO_GATE];
    end
    cmp_val("modulator b gate", 0, g1);
    cmp_val("serial port gate", 1, g2);
    cmp_val("short address upper", {2'b01, 16'h1234}, short_address[23:6]);
    ext_mem <= 1'b1;
    repeat (4) @(posedge system_clock);
    cmp_val("debug off pair", 0, debug_access_en);
    bus(1'b1, SIU_IDX_SAH, 16'h0003);
    bus(1'b1, SIU_IDX_SAL, 16'hFFFF);
    repeat (6) @(posedge system_clock);
    cmp_val("debug at pair", 1, debug_access_en);
    ext_mem <= 1'b0;
    bus(1'b1, SIU_IDX_CONTROL, 16'h0004);
    bus(1'b1, SIU_IDX_CONTROL, 16'h0000);
    bus(1'b0, SIU_IDX_STATUS, 16'h0000);
    cmp_val("permanent stop", 1, rd[10]);
    bus(1'b1, SIU_IDX_CONTROL, 16'h0010);
    wait_rel(1'b0);
    wait_rel(1'b1);
    cmp_val("software reset windows", 1, n >= 3 * WIN && n < POR);
    bus(1'b0, SIU_IDX_STATUS, 16'h0000);
    cmp_val("permanent cleared", 0, rd[11:10]);
    watchdog_rst <= 1'b1;
    repeat (3) @(posedge system_clock);
    watchdog_rst <= 1'b0;
    wait_rel(1'b0);
    wait_rel(1'b1);
    cmp_val("watchdog windows", 1, n >= 3 * WIN && n < POR);
    pm_step(5'h08, 2'b01);
    pm_step(5'h04, 2'b11);
    pm_step(5'h10, 2'b00);
    pm_step(5'h04, 2'b00);
    pm_step(5'h01, 2'b11);
    pm_step(5'h10, 2'b00);
    pm_step(5'h02, 2'b11);
    bus(1'b1, SIU_IDX_CONTROL, 16'h0001);
    pm_step(5'h10, 2'b11);
    bus(1'b1, SIU_IDX_CONTROL, 16'h0000);
    pm_step(5'h10, 2'b00);
    lock <= 1'b1;
    ext_rst_n <= 1'b0;
    @(negedge system_clock);
    cmp_val("async assert", 0, gate_out.core_rel);
    @(posedge system_clock);
    ext_rst_n <= 1'b1;
    wait_rel(1'b1);
    cmp_val("pin reset windows", 1, n >= 3 * WIN && n < POR);
    cmp_val("stop exit by reset", 1, gate_out.core_en);
    cmp_val("secure mode", 1, secure_mode);
    cmp_val("secure interlocks", 0, {debug_access_en, ext_program_en, boot_external});
    stop_test();
  end
endmodule : system_clock_reset_power_control_bench
